/* gpio_cfg.svh */
`ifndef GPIO_CFG_SVH
`define GPIO_CFG_SVH
// register byte offsets
`define OFS_PIN_CFG 12'h088
`define OFS_INT_STATUS 12'h0c0
`define OFS_INT_ENABLE 12'h0c4
// field positions in the pin configuration word
`define POS_PIN_DATA 0
`define POS_GP_OUT 3
`define POS_DIR 8
`define POS_BUF 16
`define POS_EE_SEL 20
`define POS_POL 24
`define POS_LED 28
// writable bits of the configuration word
`define CFG_WMASK 32'h7777071f
`define CFG_RESET 32'h00000000
// glitch filter: least active time in ns, and clock period in ns
`define FILT_NS 40
`define PCLK_NS 25
// cycles a level must stand: strictly more than 40 ns, rounded up
`define FILT_CYC ((`FILT_NS / `PCLK_NS) + 1)
`endif

/* gpio_pkg.sv */
package gpio_pkg;
  // routing of the two eeprom pins
  typedef enum logic [2:0] {
    EE_EEPROM = 3'h0,
    EE_GPO_GPO = 3'h1,
    EE_RSV2 = 3'h2,
    EE_GPO_RXDV = 3'h3,
    EE_RSV4 = 3'h4,
    EE_TXEN_GPO = 3'h5,
    EE_TXEN_RXDV = 3'h6,
    EE_CLKS = 3'h7
  } ee_sel_type;
endpackage

/* level_filter.sv */
`timescale 1ns/100ps
`include "gpio_cfg.svh"
// ==========================================
// level filter: output rises after the input has been active long enough
module level_filter (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // synchronised active level
  input wire logic active,
  // qualified level
  output logic qualified
);
  typedef struct packed {
    logic [2:0] cnt;
    logic q;
  } filt_state_type;
  filt_state_type st_ff, nxt_st;

  // count consecutive active cycles, restart on any drop
  always_comb begin
    nxt_st = st_ff;
    if (!active) begin
      nxt_st.cnt = 3'h0;
      nxt_st.q = 1'b0;
    end else if (st_ff.cnt != 3'(`FILT_CYC)) begin
      nxt_st.cnt = st_ff.cnt + 3'h1;
    end else begin
      nxt_st.q = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign qualified = st_ff.q;
endmodule // level_filter

/* gpio_pin_ctrl.sv */
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`include "gpio_cfg.svh"
module gpio_pin_ctrl (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // three shared gpio / led pins
  input wire logic [2:0] pin_data_in,
  output logic [2:0] pin_data_out,
  output logic [2:0] pin_data_oe,
  // led status sources from the core
  input wire logic [2:0] led_status,
  // eeprom controller side
  input wire logic eeprom_data_out,
  input wire logic eeprom_data_oe,
  output logic eeprom_data_in,
  input wire logic eeprom_clock_out,
  // internal debug sources: mac tx enable, internal phy rx valid, phy tx and rx clocks
  input wire logic mac_tx_en,
  input wire logic phy_rx_dv,
  input wire logic phy_tx_clk,
  input wire logic phy_rx_clk,
  // eeprom data and clock pins
  input wire logic eeprom_data_pin_in,
  output logic eeprom_data_pin_out,
  output logic eeprom_data_pin_oe,
  output logic eeprom_clock_pin_out,
  output logic eeprom_clock_pin_oe,
  // interrupt to host
  output logic irq
);
  // ==========================================
  // state
  typedef struct packed {
    logic [31:0] cfg;
    logic [2:0] sts;
    logic [2:0] ena;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [2:0] s1;
    logic [2:0] s2;
    logic e1;
    logic e2;
    logic [2:0] pout;
    logic [2:0] poe;
    logic ee_in;
    logic ee_dout;
    logic ee_doe;
    logic ee_cout;
    logic ee_coe;
    logic irq;
  } ctrl_state_type;
  ctrl_state_type st_ff, nxt_st;

  logic [2:0] qual; // filtered active levels
  logic [2:0] act; // raw active level per pin
  logic setup; // apb setup phase
  logic [31:0] wmask; // byte lane mask
  logic [31:0] rd_cfg; // configuration word as read back
  gpio_pkg::ee_sel_type sel; // eeprom pin selection

  // ==========================================
  // interrupt qualification
  assign act = ~(st_ff.s2 ^ st_ff.cfg[`POS_POL +: 3]);

  for (genvar i = 0; i < 3; i++) begin : g_filt
    level_filter u_filt (
      .pclk(pclk),
      .presetn(presetn),
      .active(act[i]),
      .qualified(qual[i])
    );
  end

  assign setup = psel && !penable;
  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign sel = gpio_pkg::ee_sel_type'(st_ff.cfg[`POS_EE_SEL +: 3]);
  // data bits read the synchronised pin, never the written value
  assign rd_cfg = {st_ff.cfg[31:3], st_ff.s2};

  // ==========================================
  // next state
  always_comb begin
    nxt_st = st_ff;
    // pins pass two flops before any logic looks at them
    nxt_st.s1 = pin_data_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.e1 = eeprom_data_pin_in;
    nxt_st.e2 = st_ff.e1;
    // apb: answer one cycle after setup, ready for one cycle
    nxt_st.ready = setup;
    nxt_st.err = 1'b0;
    nxt_st.rdata = 32'h0;
    // hardware set of sticky status; set wins over clear below
    if (setup) begin
      if (paddr == `OFS_PIN_CFG) begin
        if (pwrite) begin
          // reserved bits stay zero through the mask
          nxt_st.cfg = (st_ff.cfg & ~(wmask & `CFG_WMASK)) |
                       (pwdata & wmask & `CFG_WMASK);
        end else begin
          nxt_st.rdata = rd_cfg;
        end
      end else if (paddr == `OFS_INT_STATUS) begin
        if (pwrite) begin
          // write one to clear
          if (pstrb[0]) begin
            nxt_st.sts = st_ff.sts & ~pwdata[2:0];
          end
        end else begin
          nxt_st.rdata = {29'h0, st_ff.sts};
        end
      end else if (paddr == `OFS_INT_ENABLE) begin
        if (pwrite) begin
          if (pstrb[0]) begin
            nxt_st.ena = pwdata[2:0];
          end
        end else begin
          nxt_st.rdata = {29'h0, st_ff.ena};
        end
      end else begin
        // unmapped address: error, read data zero
        nxt_st.err = 1'b1;
      end
    end
    // level-sensitive: status re-sets while the level stays active
    nxt_st.sts = nxt_st.sts | qual;
    nxt_st.irq = |(st_ff.sts & st_ff.ena);

    // gpio pins: led takes priority over gpio function
    for (int i = 0; i < 3; i++) begin
      if (st_ff.cfg[`POS_LED + i]) begin
        // leds are driven actively low-on push-pull
        nxt_st.pout[i] = ~led_status[i];
        nxt_st.poe[i] = 1'b1;
      end else if (st_ff.cfg[`POS_DIR + i]) begin
        if (st_ff.cfg[`POS_BUF + i]) begin
          nxt_st.pout[i] = st_ff.cfg[`POS_PIN_DATA + i];
          nxt_st.poe[i] = 1'b1;
        end else begin
          // open drain: only ever pull low
          nxt_st.pout[i] = 1'b0;
          nxt_st.poe[i] = ~st_ff.cfg[`POS_PIN_DATA + i];
        end
      end else begin
        nxt_st.pout[i] = 1'b0;
        nxt_st.poe[i] = 1'b0;
      end
    end

    // eeprom pin routing; reserved codes park both pins as inputs
    nxt_st.ee_in = st_ff.e2;
    nxt_st.ee_coe = 1'b1;
    nxt_st.ee_doe = 1'b1;
    case (sel)
      gpio_pkg::EE_EEPROM: begin
        nxt_st.ee_dout = eeprom_data_out;
        nxt_st.ee_doe = eeprom_data_oe;
        nxt_st.ee_cout = eeprom_clock_out;
      end
      gpio_pkg::EE_GPO_GPO: begin
        nxt_st.ee_dout = st_ff.cfg[`POS_GP_OUT];
        nxt_st.ee_cout = st_ff.cfg[`POS_GP_OUT + 1];
      end
      gpio_pkg::EE_GPO_RXDV: begin
        nxt_st.ee_dout = st_ff.cfg[`POS_GP_OUT];
        nxt_st.ee_cout = phy_rx_dv;
      end
      gpio_pkg::EE_TXEN_GPO: begin
        nxt_st.ee_dout = mac_tx_en;
        nxt_st.ee_cout = st_ff.cfg[`POS_GP_OUT + 1];
      end
      gpio_pkg::EE_TXEN_RXDV: begin
        nxt_st.ee_dout = mac_tx_en;
        nxt_st.ee_cout = phy_rx_dv;
      end
      gpio_pkg::EE_CLKS: begin
        // clocks pass through a flop: fine for debug visibility only
        nxt_st.ee_dout = phy_tx_clk;
        nxt_st.ee_cout = phy_rx_clk;
      end
      default: begin
        // reserved: host must not use these
        nxt_st.ee_dout = 1'b0;
        nxt_st.ee_doe = 1'b0;
        nxt_st.ee_cout = 1'b0;
        nxt_st.ee_coe = 1'b0;
      end
    endcase
  end

  // ==========================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flops
  assign prdata = st_ff.rdata;
  assign pready = st_ff.ready;
  assign pslverr = st_ff.err;
  assign pin_data_out = st_ff.pout;
  assign pin_data_oe = st_ff.poe;
  assign eeprom_data_in = st_ff.ee_in;
  assign eeprom_data_pin_out = st_ff.ee_dout;
  assign eeprom_data_pin_oe = st_ff.ee_doe;
  assign eeprom_clock_pin_out = st_ff.ee_cout;
  assign eeprom_clock_pin_oe = st_ff.ee_coe;
  assign irq = st_ff.irq;
endmodule // gpio_pin_ctrl

/* gpio_pin_ctrl_monitor.sv */
`timescale 1ns/100ps
`include "gpio_cfg.svh"
// ======
// port checker: shadows the config word from apb writes
module gpio_pin_ctrl_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins and sources
  input wire logic [2:0] pin_data_out,
  input wire logic [2:0] pin_data_oe,
  input wire logic [2:0] led_status,
  input wire logic phy_tx_clk,
  input wire logic phy_rx_clk,
  input wire logic eeprom_data_pin_out,
  input wire logic eeprom_clock_pin_out,
  input wire logic irq
);
  logic [31:0] cfg_ff; // shadow config; the bench always writes all lanes
  // same edge as the design's own register update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= 32'h0;
    end else if (psel && !penable && pwrite && paddr == `OFS_PIN_CFG) begin
      cfg_ff <= pwdata;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_pulse_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready pulse wrong");
  slverr_ready_a: assert property (pslverr |-> pready) else $error("slverr without ready");
  reset_quiet_a: assert property ($rose(presetn) |-> !irq && pin_data_oe == 3'h0)
    else $error("outputs active after reset");
  led_drive_a: assert property (cfg_ff[28] |=> pin_data_oe[0] &&
    pin_data_out[0] == !$past(led_status[0])) else $error("led pin wrong");
  dir_input_a: assert property (!cfg_ff[28] && !cfg_ff[8] |=> !pin_data_oe[0])
    else $error("input pin driven");
  open_drain_a: assert property (!cfg_ff[28] && cfg_ff[8] && !cfg_ff[16] |=>
    !pin_data_out[0] && pin_data_oe[0] == !$past(cfg_ff[0])) else $error("open drain wrong");
  push_pull_a: assert property (!cfg_ff[28] && cfg_ff[8] && cfg_ff[16] |=>
    pin_data_oe[0] && pin_data_out[0] == $past(cfg_ff[0])) else $error("push pull wrong");
  gpo_route_a: assert property (cfg_ff[22:20] == 3'h1 |=>
    {eeprom_clock_pin_out, eeprom_data_pin_out} == $past(cfg_ff[4:3]))
    else $error("general outputs wrong");
  phy_clock_a: assert property (cfg_ff[22:20] == 3'h7 |=>
    {eeprom_data_pin_out, eeprom_clock_pin_out} == $past({phy_tx_clk, phy_rx_clk}))
    else $error("clock routing wrong");
  cover property (cfg_ff[22:20] == 3'h7);
  cover property ($rose(irq));
  cover property (pslverr);
endmodule // gpio_pin_ctrl_monitor
bind gpio_pin_ctrl gpio_pin_ctrl_monitor mon (.*);

/* pin_partner.sv */
`timescale 1ns/100ps
// ======
// board side: a driven pin wins, a released one shows the board level
module pin_partner (
  // gpio pins
  input wire logic [2:0] pin_data_out,
  input wire logic [2:0] pin_data_oe,
  input wire logic [2:0] board_level,
  output logic [2:0] pin_data_in,
  // eeprom data line, pulled up on the board
  input wire logic eeprom_data_pin_out,
  input wire logic eeprom_data_pin_oe,
  output logic eeprom_data_pin_in
);
  assign pin_data_in = (pin_data_oe & pin_data_out) | (~pin_data_oe & board_level);
  assign eeprom_data_pin_in = eeprom_data_pin_oe ? eeprom_data_pin_out : 1'b1;
endmodule // pin_partner

/* test_gpio_led_eeprom_pin_config.sv */
`timescale 1ns/100ps
`include "gpio_cfg.svh"
// ======
// bench: apb driver queues read notes, a watcher compares them
module test_gpio_led_eeprom_pin_config;
  logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pready, pslverr, irq, eeprom_data_in, eeprom_data_pin_in, eeprom_data_pin_out;
  logic eeprom_data_pin_oe, eeprom_clock_pin_out, eeprom_clock_pin_oe;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, seed_ff = 32'hca19, v;
  logic [3:0] pstrb = 4'hf; // full words only
  logic [2:0] pin_data_in, pin_data_out, pin_data_oe, led_status = 3'h5, board_level = 3'h0;
  logic mac_tx_en = 0, phy_rx_dv = 0, phy_tx_clk = 0, phy_rx_clk = 0;
  logic eeprom_data_out = 0, eeprom_data_oe = 0, eeprom_clock_out = 0;
  logic [32:0] exp_q[$];
  int miscompares = 0, n_checks = 0, cyc = 0;
  gpio_pin_ctrl dut (.*);
  pin_partner board (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // random internal sources, changed right after each edge
  always @(posedge pclk) begin
    seed_ff <= lfsr(seed_ff);
    {mac_tx_en, phy_rx_dv, phy_tx_clk, phy_rx_clk} <= seed_ff[3:0];
    {eeprom_data_out, eeprom_data_oe, eeprom_clock_out} <= seed_ff[6:4];
  end
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one apb transfer; reads leave their expected value in the queue
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                      input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    // look at pready mid-cycle, where it has settled, then finish on the next rising edge
    do @(negedge pclk); while (pready !== 1'b1);
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d, 33'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0, {1'b0, e});
  endtask
  // watcher: read data is looked at mid-cycle, while the one-cycle answer stands
  always @(negedge pclk) begin
    if (pready && psel && penable && !pwrite && exp_q.size() > 0) begin
      chk({pslverr, prdata}, exp_q.pop_front());
    end
  end
  // a hang ends the run as a failure
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFS_PIN_CFG, 32'h0);
    $display("reset test done");
    wr(`OFS_PIN_CFG, 32'hffffffff);
    repeat (5) @(posedge pclk);
    rd(`OFS_PIN_CFG, 32'h7777071a);
    for (int i = 0; i < 8; i++) begin
      if (i == 2 || i == 4) continue; // reserved codes never written
      v = {9'h0, i[2:0], 15'h0, seed_ff[4:3], 3'h0};
      wr(`OFS_PIN_CFG, v);
      // pins released by the led setting need the two sync flops to settle
      repeat (3) @(posedge pclk);
      rd(`OFS_PIN_CFG, v);
    end
    $display("routing test done");
    wr(`OFS_PIN_CFG, 32'h00010703);
    repeat (5) @(posedge pclk);
    rd(`OFS_PIN_CFG, 32'h00010701);
    $display("pin drive test done");
    wr(`OFS_PIN_CFG, 32'h07000000);
    wr(`OFS_INT_ENABLE, 32'h1);
    wr(`OFS_INT_STATUS, 32'h7);
    board_level <= 3'h1;
    @(posedge pclk);
    board_level <= 3'h0;
    repeat (10) @(posedge pclk);
    chk({32'h0, irq}, 33'h0);
    rd(`OFS_INT_STATUS, 32'h0);
    board_level <= 3'h1;
    repeat (10) @(posedge pclk);
    chk({32'h0, irq}, 33'h1);
    board_level <= 3'h0;
    wr(`OFS_INT_ENABLE, 32'h0);
    repeat (3) @(posedge pclk);
    chk({32'h0, irq}, 33'h0);
    rd(`OFS_INT_STATUS, 32'h1);
    wr(`OFS_INT_STATUS, 32'h1);
    rd(`OFS_INT_STATUS, 32'h0);
    xfer(12'h0f0, 1'b0, 32'h0, {1'b1, 32'h0});
    $display("interrupt test done");
    results();
  end
endmodule // test_gpio_led_eeprom_pin_config
